// ===== hdl/fuzzy_params.svh
`ifndef FUZZY_PARAMS_SVH
`define FUZZY_PARAMS_SVH

// ----------------------------------------
// Pointer steps, list codes and grading constants
// ----------------------------------------
`define FZ_MF_STEP      16'h0004
`define FZ_IN_STEP      16'h0001
`define FZ_LIST_STEP    16'h0001
`define FZ_SEP_CODE     8'hFE
`define FZ_END_CODE     8'hFF
`define FZ_GRADE_MAX    8'hFF
`define FZ_GRADE_ZERO   8'h00
`define FZ_SLOPE_VERT   8'h00
`define FZ_MF_LAST_IDX  2'h3

// ----------------------------------------
// Divider and reset values
// ----------------------------------------
`define FZ_DIV_STEPS    6'h20
`define FZ_RST_ADDR     16'h0000
`define FZ_RST_BYTE     8'h00

`endif

// ===== hdl/fuzzy_pkg.sv
package fuzzy_pkg;

    typedef enum logic [1:0] {
        OP_GRADE        = 2'h0,
        OP_RULE         = 2'h1,
        WEIGHTED_SUM_OP = 2'h2,
        LONG_DIVIDE_OP  = 2'h3
    } fz_op_t;

    typedef enum logic [8:0] {
        S_IDLE     = 9'h001,
        S_MF_RD    = 9'h002,
        S_MF_WR    = 9'h004,
        S_RV_FETCH = 9'h008,
        S_RV_OPND  = 9'h010,
        S_RV_WR    = 9'h020,
        S_WS_S     = 9'h040,
        S_WS_F     = 9'h080,
        S_DIV      = 9'h100
    } fz_state_t;

    typedef struct packed {
        fz_op_t      op;
        logic [7:0]  acc;
        logic [7:0]  count;
        logic [15:0] ptr_x;
        logic [15:0] ptr_y;
        logic        v_flag;
        logic [31:0] dividend;
        logic [15:0] divisor;
    } fz_cmd_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  count;
        logic [15:0] ptr_x;
        logic [15:0] ptr_y;
        logic        v_flag;
        logic [31:0] sum_prod;
        logic [15:0] sum_w;
        logic [15:0] quotient;
        logic [15:0] remainder;
        logic        div_ovf;
        logic        div_zero;
        logic        interrupted;
    } fz_res_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fz_mem_t;

endpackage

// ===== hdl/fuzzy_inference_instr_unit.sv
`timescale 1ns/1ns
`include "fuzzy_params.svh"
// How it works
// - Grading writes rising-side grade at accumulator input if sloped and at most FF, else falling-side grade capped at FF, to byte at second pointer.
// - After grading, first pointer advances four, second pointer advances one.
// - Each list element other than the separator and end codes is an unsigned byte offset added to second pointer.
// - Separator code marks antecedent/consequent boundary and is no offset.
// - Every separator inverts the phase flag; clear means antecedents.
// - Antecedent phase keeps running minimum of accumulator and referenced inputs.
// - Rule evaluation loops over elements and stops on end-of-list code.
// - Rule evaluation yields to pending interrupts and resumes correctly later.
// - Weighted sum accumulates position times output and output sum per iteration.
// - Long divide splits 32-bit dividend by 16-bit divisor into quotient.
// - Consequent phase stores truth only where the output holds less.
// - Zero slope byte means a vertical side.
// - Grade is zero outside the closed interval between the two points.
module fuzzy_inference_instr_unit
    import fuzzy_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire fz_cmd_t    cmd_in,
    input  wire logic       irq_pend_in,
    input  wire logic [7:0] mem_rdata_in,
    input  wire logic       mem_ack_in,
    output logic            busy_out,
    output logic            done_out,
    output fz_res_t         res_out,
    output fz_mem_t         mem_out
);

    // ----------------------------------------
    // Trapezoid evaluation
    // ----------------------------------------
    function automatic logic [7:0] grade_fn(input logic [7:0] a, input logic [7:0] p1,
                                            input logic [7:0] p2, input logic [7:0] s1,
                                            input logic [7:0] s2);
        logic        outside;
        logic [15:0] g1;
        logic [15:0] g2;
        logic [7:0]  g;
        outside = (a < p1) || (a > p2);
        g1 = outside ? 16'h0000 : (16'(a - p1) * 16'(s1));
        g2 = outside ? 16'h0000 : (16'(p2 - a) * 16'(s2));
        if (!outside && ((s2 == `FZ_SLOPE_VERT) || (g2 > 16'h00FF))) begin
            g = `FZ_GRADE_MAX;
        end else begin
            g = g2[7:0];
        end
        if (!((s1 == `FZ_SLOPE_VERT) || (g1 > 16'h00FF))) begin
            g = g1[7:0];
        end
        return g;
    endfunction

    fz_state_t   state_reg, state_next;
    fz_op_t      op_reg, op_next;
    logic [7:0]  acc_reg, acc_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [15:0] x_reg, x_next;
    logic [15:0] y_reg, y_next;
    logic        v_reg, v_next;
    logic [31:0] sp_reg, sp_next;
    logic [15:0] sw_reg, sw_next;
    logic [7:0]  mf_reg [3];
    logic [7:0]  mf_next [3];
    logic [1:0]  idx_reg, idx_next;
    logic [7:0]  ofs_reg, ofs_next;
    logic [31:0] dvd_reg, dvd_next;
    logic [15:0] dsr_reg, dsr_next;
    logic [15:0] rem_reg, rem_next;
    logic [5:0]  dcnt_reg, dcnt_next;
    logic        ovf_reg, ovf_next;
    logic        dz_reg, dz_next;
    logic        intr_reg, intr_next;
    logic        busy_reg, busy_next;
    logic        done_reg, done_next;
    fz_mem_t     mem_reg, mem_next;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [16:0] trial;
        logic        fin;
        trial = 17'h00000;
        fin = 1'b0;
        state_next = state_reg;
        op_next = op_reg;
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        x_next = x_reg;
        y_next = y_reg;
        v_next = v_reg;
        sp_next = sp_reg;
        sw_next = sw_reg;
        mf_next = mf_reg;
        idx_next = idx_reg;
        ofs_next = ofs_reg;
        dvd_next = dvd_reg;
        dsr_next = dsr_reg;
        rem_next = rem_reg;
        dcnt_next = dcnt_reg;
        ovf_next = ovf_reg;
        dz_next = dz_reg;
        intr_next = intr_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        mem_next = mem_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (start_in) begin
                    op_next = cmd_in.op;
                    acc_next = cmd_in.acc;
                    cnt_next = cmd_in.count;
                    x_next = cmd_in.ptr_x;
                    y_next = cmd_in.ptr_y;
                    v_next = cmd_in.v_flag;
                    intr_next = 1'b0;
                    busy_next = 1'b1;
                    idx_next = 2'h0;
                    unique case (cmd_in.op)
                        OP_GRADE: state_next = S_MF_RD;
                        OP_RULE:  state_next = S_RV_FETCH;
                        WEIGHTED_SUM_OP: begin
                            sp_next = 32'h00000000;
                            sw_next = 16'h0000;
                            if (cmd_in.count == 8'h00) begin
                                fin = 1'b1;
                            end else begin
                                state_next = S_WS_S;
                            end
                        end
                        LONG_DIVIDE_OP: begin
                            dvd_next = cmd_in.dividend;
                            dsr_next = cmd_in.divisor;
                            rem_next = 16'h0000;
                            dcnt_next = `FZ_DIV_STEPS;
                            dz_next = (cmd_in.divisor == 16'h0000);
                            ovf_next = 1'b0;
                            if (cmd_in.divisor == 16'h0000) begin
                                fin = 1'b1;
                            end else begin
                                state_next = S_DIV;
                            end
                        end
                    endcase
                end
            end
            S_MF_RD: begin
                if (mem_ack_in) begin
                    if (idx_reg == `FZ_MF_LAST_IDX) begin
                        mem_next.wdata = grade_fn(acc_reg, mf_reg[0], mf_reg[1],
                                                  mf_reg[2], mem_rdata_in);
                        state_next = S_MF_WR;
                    end else begin
                        mf_next[idx_reg] = mem_rdata_in;
                        idx_next = idx_reg + 2'h1;
                    end
                end
            end
            S_MF_WR: begin
                if (mem_ack_in) begin
                    x_next = x_reg + `FZ_MF_STEP;
                    y_next = y_reg + `FZ_IN_STEP;
                    fin = 1'b1;
                end
            end
            S_RV_FETCH: begin
                if (mem_ack_in) begin
                    x_next = x_reg + `FZ_LIST_STEP;
                    if (mem_rdata_in == `FZ_END_CODE) begin
                        fin = 1'b1;
                    end else if (mem_rdata_in == `FZ_SEP_CODE) begin
                        v_next = !v_reg;
                        // Back to antecedents: next rule starts a fresh minimum
                        if (v_reg) begin
                            acc_next = `FZ_GRADE_MAX;
                        end
                        if (irq_pend_in) begin
                            intr_next = 1'b1;
                            fin = 1'b1;
                        end
                    end else begin
                        ofs_next = mem_rdata_in;
                        state_next = S_RV_OPND;
                    end
                end
            end
            S_RV_OPND, S_RV_WR: begin
                if (mem_ack_in) begin
                    state_next = S_RV_FETCH;
                    if (state_reg == S_RV_OPND && !v_reg) begin
                        if (mem_rdata_in < acc_reg) begin
                            acc_next = mem_rdata_in;
                        end
                    end else if (state_reg == S_RV_OPND && mem_rdata_in < acc_reg) begin
                        state_next = S_RV_WR;
                    end
                    // Yield only between elements so no read-modify-write is split
                    if (state_next == S_RV_FETCH && irq_pend_in) begin
                        intr_next = 1'b1;
                        fin = 1'b1;
                    end
                end
            end
            S_WS_S: begin
                if (mem_ack_in) begin
                    ofs_next = mem_rdata_in;
                    state_next = S_WS_F;
                end
            end
            S_WS_F: begin
                if (mem_ack_in) begin
                    sp_next = sp_reg + 32'(16'(ofs_reg) * 16'(mem_rdata_in));
                    sw_next = sw_reg + 16'(mem_rdata_in);
                    x_next = x_reg + `FZ_LIST_STEP;
                    y_next = y_reg + `FZ_LIST_STEP;
                    cnt_next = cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01) begin
                        fin = 1'b1;
                    end else begin
                        state_next = S_WS_S;
                    end
                end
            end
            S_DIV: begin
                // Restoring divide, one quotient bit a cycle; trades speed for area
                trial = {rem_reg, dvd_reg[31]} - {1'b0, dsr_reg};
                if (!trial[16]) begin
                    rem_next = trial[15:0];
                    dvd_next = {dvd_reg[30:0], 1'b1};
                end else begin
                    rem_next = {rem_reg[14:0], dvd_reg[31]};
                    dvd_next = {dvd_reg[30:0], 1'b0};
                end
                dcnt_next = dcnt_reg - 6'h01;
                if (dcnt_reg == 6'h01) begin
                    ovf_next = (dvd_next[31:16] != 16'h0000);
                    fin = 1'b1;
                end
            end
        endcase
        if (fin) begin
            state_next = S_IDLE;
            busy_next = 1'b0;
            done_next = 1'b1;
        end
        mem_next.req = 1'b1;
        mem_next.we = 1'b0;
        unique case (state_next)
            S_MF_RD:    mem_next.addr = x_next + 16'(idx_next);
            S_MF_WR:    mem_next.addr = y_next;
            S_RV_FETCH: mem_next.addr = x_next;
            S_RV_OPND:  mem_next.addr = y_next + 16'(ofs_next);
            S_WS_S:     mem_next.addr = x_next;
            S_WS_F:     mem_next.addr = y_next;
            S_RV_WR:    mem_next.addr = y_next + 16'(ofs_next);
            S_IDLE, S_DIV: begin
                mem_next.req = 1'b0;
            end
        endcase
        if (state_next == S_MF_WR || state_next == S_RV_WR) begin
            mem_next.we = 1'b1;
        end
        if (state_next == S_RV_WR) begin
            mem_next.wdata = acc_next;
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_reg <= S_IDLE;
            op_reg <= OP_GRADE;
            acc_reg <= `FZ_RST_BYTE;
            cnt_reg <= `FZ_RST_BYTE;
            x_reg <= `FZ_RST_ADDR;
            y_reg <= `FZ_RST_ADDR;
            v_reg <= 1'b0;
            sp_reg <= 32'h00000000;
            sw_reg <= 16'h0000;
            mf_reg <= '{`FZ_RST_BYTE, `FZ_RST_BYTE, `FZ_RST_BYTE};
            idx_reg <= 2'h0;
            ofs_reg <= `FZ_RST_BYTE;
            dvd_reg <= 32'h00000000;
            dsr_reg <= 16'h0000;
            rem_reg <= 16'h0000;
            dcnt_reg <= 6'h00;
            ovf_reg <= 1'b0;
            dz_reg <= 1'b0;
            intr_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            mem_reg <= '0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            x_reg <= x_next;
            y_reg <= y_next;
            v_reg <= v_next;
            sp_reg <= sp_next;
            sw_reg <= sw_next;
            mf_reg <= mf_next;
            idx_reg <= idx_next;
            ofs_reg <= ofs_next;
            dvd_reg <= dvd_next;
            dsr_reg <= dsr_next;
            rem_reg <= rem_next;
            dcnt_reg <= dcnt_next;
            ovf_reg <= ovf_next;
            dz_reg <= dz_next;
            intr_reg <= intr_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            mem_reg <= mem_next;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;
    assign mem_out = mem_reg;
    assign res_out = '{acc: acc_reg, count: cnt_reg, ptr_x: x_reg, ptr_y: y_reg,
                       v_flag: v_reg, sum_prod: sp_reg, sum_w: sw_reg,
                       quotient: dvd_reg[15:0], remainder: rem_reg, div_ovf: ovf_reg,
                       div_zero: dz_reg, interrupted: intr_reg};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_grade_ptr_step:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_MF_WR && mem_ack_in) |=>
        (x_reg == $past(x_reg) + `FZ_MF_STEP) && (y_reg == $past(y_reg) + `FZ_IN_STEP) && done_out)
        else $error("grading pointers did not advance");
    a_grade_write_dest:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_MF_WR) |-> (mem_out.req && mem_out.we && mem_out.addr == y_reg))
        else $error("grade not written at second pointer");
    a_rule_sep_flip:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_FETCH && mem_ack_in && mem_rdata_in == `FZ_SEP_CODE) |=>
        (v_reg != $past(v_reg)) && (state_reg == S_RV_FETCH || intr_reg))
        else $error("separator did not flip phase");
    a_rule_offset_addr:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_OPND) |-> (mem_out.addr == y_reg + 16'(ofs_reg) && !mem_out.we))
        else $error("operand address is not base plus offset");
    a_rule_min_keep:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_OPND && mem_ack_in && !v_reg) |=>
        (acc_reg <= $past(acc_reg)) && (acc_reg <= $past(mem_rdata_in)))
        else $error("running minimum not kept");
    a_rule_end_stop:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_FETCH && mem_ack_in && mem_rdata_in == `FZ_END_CODE) |=>
        done_out && !busy_out && !mem_out.req && !intr_reg)
        else $error("end code did not stop evaluation");
    a_rule_max_store:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_OPND && mem_ack_in && v_reg && mem_rdata_in >= acc_reg) |=>
        (state_reg != S_RV_WR))
        else $error("larger fuzzy output overwritten");
    a_rule_irq_yield:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_RV_OPND && mem_ack_in && !v_reg && irq_pend_in) |=>
        done_out && intr_reg && x_reg == $past(x_reg))
        else $error("evaluation did not yield to interrupt");
    a_wsum_count:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_WS_F && mem_ack_in) |=>
        (cnt_reg == $past(cnt_reg) - 8'h01) && (sw_reg == $past(sw_reg) + 16'($past(mem_rdata_in))))
        else $error("weighted sum step wrong");
    a_ldiv_rem_bound:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (done_out && op_reg == LONG_DIVIDE_OP && !dz_reg) |-> (rem_reg < dsr_reg))
        else $error("divide remainder not below divisor");

endmodule // fuzzy_inference_instr_unit

// ===== verification/fuzzy_mem_model.sv
`timescale 1ns/1ns
module fuzzy_mem_model
    import fuzzy_pkg::*;
(
    input  wire logic    clk_in,
    input  wire fz_mem_t mem_in,
    input  wire logic    slow_in,
    output logic         ack_out,
    output logic [7:0]   rdata_out
);
    logic [7:0] mem [0:65535];
    logic       phase_reg = 1'b0;
    logic [7:0] last_reg  = 8'h00;

    // ----------------------------------------
    // Answer side
    // ----------------------------------------
    // Slow mode acks every other cycle, so each access waits a cycle or not
    assign ack_out = mem_in.req && (!slow_in || phase_reg);
    // Without an ack the lines show the inverse of the last byte, never a stale match
    assign rdata_out = (ack_out && !mem_in.we) ? mem[mem_in.addr] : ~last_reg;

    always @(posedge clk_in) begin
        phase_reg <= ~phase_reg;
        if (ack_out && mem_in.we) begin
            mem[mem_in.addr] <= mem_in.wdata;
        end
        if (ack_out && !mem_in.we) begin
            last_reg <= mem[mem_in.addr];
        end
    end
endmodule // fuzzy_mem_model

// ===== verification/fuzzy_inference_instr_unit_tb.sv
`timescale 1ns/1ns
module fuzzy_inference_instr_unit_tb;
    import fuzzy_pkg::*;
    logic       clk_in      = 1'b0;
    logic       rst_b_in    = 1'b0;
    logic       start_in    = 1'b0;
    fz_cmd_t    cmd_in      = '0;
    logic       irq_pend_in = 1'b0;
    logic       slow        = 1'b0;
    logic [7:0] mem_rdata_in;
    logic       mem_ack_in;
    logic       busy_out;
    logic       done_out;
    fz_res_t    res_out;
    fz_mem_t    mem_out;
    int         errors      = 0;
    int         cmp_count   = 0;
    int         yields;
    logic [7:0] rl [12] = '{8'h02, 8'h03, 8'hFE, 8'h10, 8'hFE, 8'h00,
                            8'h01, 8'hFE, 8'h10, 8'h11, 8'hFE, 8'hFF};

    always #5 clk_in = ~clk_in;

    fuzzy_inference_instr_unit fuzzy_inference_instr_unit_inst (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .start_in(start_in), .cmd_in(cmd_in), .irq_pend_in(irq_pend_in),
        .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in), .busy_out(busy_out),
        .done_out(done_out), .res_out(res_out), .mem_out(mem_out));
    fuzzy_mem_model fuzzy_mem_model_inst (.clk_in(clk_in), .mem_in(mem_out), .slow_in(slow),
        .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Start pulse on a falling edge, then wait a bounded time for done
    task go(input fz_op_t op, input logic [7:0] a, input logic [7:0] n, input logic [15:0] px,
            input logic [15:0] py, input logic v, input logic [31:0] dd, input logic [15:0] dv);
        int k;
        @(negedge clk_in);
        cmd_in = '{op, a, n, px, py, v, dd, dv};
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        // Only an empty sum or a zero divisor finishes without ever showing busy
        check("busy", 32'(busy_out),
              32'(!((op == WEIGHTED_SUM_OP && n == 8'h00) ||
                    (op == LONG_DIVIDE_OP && dv == 16'h0000))));
        k = 0;
        while (done_out !== 1'b1 && k < 2000) begin
            @(negedge clk_in);
            k++;
        end
        check("done", 32'(done_out), 32'h1);
        check("idle", 32'(busy_out), 32'h0);
    endtask

    task do_grade(input logic [7:0] a, p1, p2, s1, s2, exp);
        fuzzy_mem_model_inst.mem[16'h0100] = p1;
        fuzzy_mem_model_inst.mem[16'h0101] = p2;
        fuzzy_mem_model_inst.mem[16'h0102] = s1;
        fuzzy_mem_model_inst.mem[16'h0103] = s2;
        fuzzy_mem_model_inst.mem[16'h0180] = 8'h5A;
        go(OP_GRADE, a, 8'h00, 16'h0100, 16'h0180, 1'b0, 32'h0, 16'h0);
        check("grade", 32'(fuzzy_mem_model_inst.mem[16'h0180]), 32'(exp));
        check("ptr_x", 32'(res_out.ptr_x), 32'h0104);
        check("ptr_y", 32'(res_out.ptr_y), 32'h0181);
    endtask

    task load_rules();
        for (int i = 0; i < 12; i++) begin
            fuzzy_mem_model_inst.mem[16'h0300 + 16'(i)] = rl[i];
        end
        fuzzy_mem_model_inst.mem[16'h0200] = 8'h80;
        fuzzy_mem_model_inst.mem[16'h0201] = 8'h30;
        fuzzy_mem_model_inst.mem[16'h0202] = 8'hC0;
        fuzzy_mem_model_inst.mem[16'h0203] = 8'h55;
        fuzzy_mem_model_inst.mem[16'h0210] = 8'h00;
        fuzzy_mem_model_inst.mem[16'h0211] = 8'h00;
    endtask

    task check_outs();
        check("out0", 32'(fuzzy_mem_model_inst.mem[16'h0210]), 32'h55);
        check("out1", 32'(fuzzy_mem_model_inst.mem[16'h0211]), 32'h30);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task test_grade();
        do_grade(8'h50, 8'h40, 8'hC0, 8'h04, 8'h04, 8'h40);
        do_grade(8'h80, 8'h40, 8'hC0, 8'h04, 8'h04, 8'hFF);
        do_grade(8'hC0, 8'h40, 8'hC0, 8'h04, 8'h00, 8'hFF);
        do_grade(8'h40, 8'h40, 8'hC0, 8'h00, 8'h04, 8'hFF);
        do_grade(8'hC1, 8'h40, 8'hC0, 8'h00, 8'h00, 8'h00);
        do_grade(8'h30, 8'h40, 8'hC0, 8'h04, 8'h04, 8'h00);
    endtask

    // Slow memory: second rule has a weaker truth and must not lower an output
    task test_rule();
        slow = 1'b1;
        load_rules();
        go(OP_RULE, 8'hFF, 8'h00, 16'h0300, 16'h0200, 1'b0, 32'h0, 16'h0);
        check_outs();
        check("v_end", 32'(res_out.v_flag), 32'h0);
        check("intr", 32'(res_out.interrupted), 32'h0);
        slow = 1'b0;
    endtask

    // Interrupt held pending: yield after every element but the end code, resume from returned state
    task test_irq();
        load_rules();
        irq_pend_in = 1'b1;
        go(OP_RULE, 8'hFF, 8'h00, 16'h0300, 16'h0200, 1'b0, 32'h0, 16'h0);
        check("y_ptr", 32'(res_out.ptr_x), 32'h0301);
        check("y_acc", 32'(res_out.acc), 32'hC0);
        yields = 0;
        while (res_out.interrupted === 1'b1 && yields < 20) begin
            yields++;
            if (yields == 3) begin
                check("y_v", 32'(res_out.v_flag), 32'h1);
            end
            go(OP_RULE, res_out.acc, 8'h00, res_out.ptr_x, 16'h0200, res_out.v_flag,
               32'h0, 16'h0);
        end
        check("yields", 32'(yields), 32'd11);
        check_outs();
        irq_pend_in = 1'b0;
    endtask

    task test_wsum();
        slow = 1'b1;
        fuzzy_mem_model_inst.mem[16'h0400] = 8'h10;
        fuzzy_mem_model_inst.mem[16'h0401] = 8'h80;
        fuzzy_mem_model_inst.mem[16'h0402] = 8'hFF;
        fuzzy_mem_model_inst.mem[16'h0410] = 8'h55;
        fuzzy_mem_model_inst.mem[16'h0411] = 8'h30;
        fuzzy_mem_model_inst.mem[16'h0412] = 8'hFF;
        go(WEIGHTED_SUM_OP, 8'h00, 8'h03, 16'h0400, 16'h0410, 1'b0, 32'h0, 16'h0);
        check("sum_prod", res_out.sum_prod, 32'h0001_1B51);
        check("sum_w", 32'(res_out.sum_w), 32'h0184);
        check("count", 32'(res_out.count), 32'h0);
        check("ptr_s", 32'(res_out.ptr_x), 32'h0403);
        check("ptr_f", 32'(res_out.ptr_y), 32'h0413);
        go(WEIGHTED_SUM_OP, 8'h00, 8'h00, 16'h0400, 16'h0410, 1'b0, 32'h0, 16'h0);
        check("sum_zero", res_out.sum_prod, 32'h0);
        slow = 1'b0;
    endtask

    task test_div();
        go(LONG_DIVIDE_OP, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0, 32'h0001_1B51, 16'h0184);
        check("quot", 32'(res_out.quotient), 32'h00BA);
        check("rem", 32'(res_out.remainder), 32'h0169);
        check("ovf0", 32'(res_out.div_ovf), 32'h0);
        go(LONG_DIVIDE_OP, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0, 32'h0000_FFFF, 16'h0001);
        check("quot_max", 32'(res_out.quotient), 32'hFFFF);
        check("ovf_edge", 32'(res_out.div_ovf), 32'h0);
        go(LONG_DIVIDE_OP, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0, 32'h0001_0000, 16'h0001);
        check("ovf1", 32'(res_out.div_ovf), 32'h1);
        go(LONG_DIVIDE_OP, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0, 32'h0000_1234, 16'h0000);
        check("dzero", 32'(res_out.div_zero), 32'h1);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge clk_in);
        rst_b_in = 1'b1;
        test_grade();
        test_rule();
        test_irq();
        test_wsum();
        test_div();
        give_verdict();
    end

    // Whole run needs a few hundred cycles; this leaves wide margin
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule // fuzzy_inference_instr_unit_tb
